// >>> verilog/uefifo_map.vh
`ifndef UEFIFO_MAP_VH
`define UEFIFO_MAP_VH
// Buffer sizes in bytes.
`define UEF_TOTAL_BYTES  28672
`define UEF_RX_BYTES     20480
`define UEF_TX_BYTES     8192
// Bulk-in block length and the largest bulk-out packet accepted.
`define UEF_BLOCK_BYTES  512
`define UEF_MAX_PKT      512
// Address widths of the two partitions.
`define UEF_RX_AW        15
`define UEF_TX_AW        13
// Encapsulation modes.
`define UEF_MODE_MULTI   1'b0
`define UEF_MODE_SINGLE  1'b1
// Handshake results from the device core for a bulk-in packet.
`define UEF_HS_ACK       2'h1
`define UEF_HS_FAIL      2'h2
`endif

// >>> verilog/uef_skid.v
// Two-entry buffer with valid and ready on both sides.
module uef_skid #(
  parameter W = 9
) (
  // Clock and reset.
  input  wire         clk_sys,
  input  wire         sys_rst,
  // Filling side.
  input  wire [W-1:0] in_data,
  input  wire         in_valid,
  output wire         in_ready,
  // Draining side.
  input  wire         out_ready,
  output wire [W-1:0] out_data,
  output wire         out_valid
);
  reg [W-1:0] mem_r [0:1];  // Two storage slots.
  reg         wp_r;         // Write slot index.
  reg         rp_r;         // Read slot index.
  reg [1:0]   cnt_r;        // Number of words held.
  wire        push;
  wire        pop;

  // Ready only while a slot is free, so a stalled drain fills the buffer.
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointer and count update.
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Data slots need no reset; they are read only when counted valid.
  always @(posedge clk_sys) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
endmodule // uef_skid

// >>> verilog/uef_fifo.v
// Operation
// - Two SRAMs, 28 kB in all: 20 kB rx, 8 kB tx.
// - Bulk-out bytes written straight into tx buffer.
// - Frames extracted from tx buffer to MAC.
// - MAC frames written straight into rx buffer.
// - Rx data sent in blocks of up to 512 bytes.
// - Bad bulk-out packet rewinds tx write pointer.
// - Failed bulk-in handshake allows packet resend.
// - Rx read head advances only after success.
// - Multi-frame or single-frame per packet encapsulation on bulk-in; bulk-out is one frame per packet.
// - Bulk-in packets assembled from stored frames.
`include "uefifo_map.vh"
module uef_fifo #(
  parameter RX_BYTES = `UEF_RX_BYTES,
  parameter TX_BYTES = `UEF_TX_BYTES
) (
  // Clock and reset.
  input  wire       clk_sys,
  input  wire       sys_rst,
  // Mode: encapsulation choice, a level.
  input  wire       encap_mode,
  // Bulk-out receiver side: bytes of a packet, last flag, bad flag.
  input  wire [7:0] bout_data,
  input  wire       bout_valid,
  input  wire       bout_last,
  input  wire       bout_err,
  output reg        bout_nak_r,
  // Ethernet MAC transmit side.
  output reg  [7:0] mtx_data_r,
  output reg        mtx_valid_r,
  output reg        mtx_last_r,
  input  wire       mtx_ready,
  // Ethernet MAC receive side.
  input  wire [7:0] mrx_data,
  input  wire       mrx_valid,
  input  wire       mrx_last,
  output reg        mrx_ready_r,
  // Bulk-in transmitter side.
  output reg  [7:0] bin_data_r,
  output reg        bin_valid_r,
  output reg        bin_last_r,
  input  wire       bin_ready,
  input  wire [1:0] bin_hs,
  input  wire       bin_hs_valid,
  // Fill status.
  output reg        rx_empty_r,
  output reg        tx_empty_r
);
  localparam RXW = `UEF_RX_AW;
  localparam TXW = `UEF_TX_AW;

  // Word in storage: data byte plus frame-end flag.
  // Two separate memories, one per region.
  reg [8:0] rxm_r [0:RX_BYTES-1];
  reg [8:0] txm_r [0:TX_BYTES-1];

  // Wrap an index at the region size.
  function [15:0] wrap;
    input [15:0] p;
    input [15:0] lim;
    begin
      wrap = (p == lim - 16'h0001) ? 16'h0000 : p + 16'h0001;
    end
  endfunction

  // Transmit buffer pointers: committed write, working write, read, counts.
  reg [TXW-1:0] tx_wc_r;
  reg [TXW-1:0] tx_ww_r;
  reg [TXW-1:0] tx_rd_r;
  reg [TXW:0]   tx_used_r;   // Committed words.
  reg [TXW:0]   tx_pend_r;   // Words of the packet in flight.
  wire          tx_push;
  wire          tx_pop;
  wire          sk_in_ready;
  wire [8:0]    sk_out;
  wire          sk_valid;
  wire [15:0]   tx_ww_inc;   // Working write pointer plus one, wrapped.
  wire [15:0]   tx_rd_inc;   // Read pointer plus one, wrapped.
  wire [TXW:0]  tx_add;      // Words committed by a good packet end.

  assign tx_push   = bout_valid & ~bout_nak_r;
  assign tx_pop    = (tx_used_r != {(TXW+1){1'b0}}) & sk_in_ready;
  assign tx_ww_inc = wrap({3'h0, tx_ww_r}, TX_BYTES[15:0]);
  assign tx_rd_inc = wrap({3'h0, tx_rd_r}, TX_BYTES[15:0]);
  // The last byte counts as well, since it is written in the commit cycle.
  assign tx_add    = (tx_push & bout_last & ~bout_err) ?
                     tx_pend_r + {{TXW{1'b0}}, 1'b1} : {(TXW+1){1'b0}};

  // Bulk-out bytes go straight to the tx region; errors rewind.
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_wc_r    <= {TXW{1'b0}};
      tx_ww_r    <= {TXW{1'b0}};
      tx_pend_r  <= {(TXW+1){1'b0}};
      bout_nak_r <= 1'b0;
    end else begin
      if (tx_push & bout_last & bout_err) begin
        tx_ww_r   <= tx_wc_r;
        tx_pend_r <= {(TXW+1){1'b0}};
      end else if (tx_push & bout_last) begin
        tx_wc_r   <= tx_ww_inc[TXW-1:0];
        tx_ww_r   <= tx_ww_inc[TXW-1:0];
        tx_pend_r <= {(TXW+1){1'b0}};
      end else if (tx_push) begin
        tx_ww_r   <= tx_ww_inc[TXW-1:0];
        tx_pend_r <= tx_pend_r + {{TXW{1'b0}}, 1'b1};
      end
      // Refuse a new packet while a full one would not fit. The refusal is a level
      // that clears by itself once the MAC has drained room; software has no part in it.
      bout_nak_r <= (tx_pend_r == {(TXW+1){1'b0}}) & ~tx_push &
                    (TX_BYTES - tx_used_r < `UEF_MAX_PKT);
    end
  end

  // Tx data store, data plus a frame-end flag.
  always @(posedge clk_sys) begin
    if (tx_push) begin
      // Without header parsing a frame ends where its packet ends, in either mode.
      txm_r[tx_ww_r] <= {bout_last, bout_data};
    end
  end

  // Committed count and read side toward the MAC.
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_used_r <= {(TXW+1){1'b0}};
      tx_rd_r   <= {TXW{1'b0}};
      tx_empty_r <= 1'b1;
    end else begin
      tx_used_r <= tx_used_r + tx_add - {{TXW{1'b0}}, tx_pop};
      if (tx_pop) begin
        tx_rd_r <= tx_rd_inc[TXW-1:0];
      end
      tx_empty_r <= (tx_used_r == {(TXW+1){1'b0}});
    end
  end

  // Buffer toward the MAC so that a MAC stall loses no byte.
  uef_skid #(.W(9)) u_skid (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_data   (txm_r[tx_rd_r]),
    .in_valid  (tx_pop),
    .in_ready  (sk_in_ready),
    .out_ready (mtx_ready | ~mtx_valid_r),
    .out_data  (sk_out),
    .out_valid (sk_valid)
  );

  // Registered MAC output; frame boundaries come from the stored flag.
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mtx_data_r  <= 8'h00;
      mtx_valid_r <= 1'b0;
      mtx_last_r  <= 1'b0;
    end else if (mtx_ready | ~mtx_valid_r) begin
      mtx_data_r  <= sk_out[7:0];
      mtx_last_r  <= sk_out[8];
      mtx_valid_r <= sk_valid;
    end
  end

  // Receive buffer: write, committed head, working read, block length.
  reg [RXW-1:0] rx_wr_r;
  reg [RXW-1:0] rx_hd_r;
  reg [RXW-1:0] rx_rw_r;
  reg [RXW:0]   rx_used_r;
  reg [RXW:0]   rx_sent_r;   // Bytes of the current block already sent.
  reg           rx_wait_r;   // Block finished, waiting for handshake.
  wire          rx_push;
  wire          rx_take;
  wire          blk_end;
  wire          hs_ok;
  wire [15:0]   rx_wr_inc;   // Write pointer plus one, wrapped.
  wire [15:0]   rx_rw_inc;   // Working read pointer plus one, wrapped.
  wire [RXW:0]  rx_sent_inc; // Bytes of the block once this byte is loaded.
  wire          rx_one_left; // The byte being loaded is the last one stored.

  assign rx_wr_inc   = wrap({1'h0, rx_wr_r}, RX_BYTES[15:0]);
  assign rx_rw_inc   = wrap({1'h0, rx_rw_r}, RX_BYTES[15:0]);
  assign rx_sent_inc = rx_sent_r + {{RXW{1'b0}}, 1'b1};
  assign rx_one_left = (rx_used_r == rx_sent_inc);
  assign rx_push = mrx_valid & mrx_ready_r;
  assign rx_take = bin_valid_r & bin_ready;
  assign hs_ok   = rx_wait_r & bin_hs_valid & (bin_hs == `UEF_HS_ACK);
  assign blk_end = bin_last_r;

  // MAC frames go straight into the rx region.
  always @(posedge clk_sys) begin
    if (rx_push) begin
      rxm_r[rx_wr_r] <= {mrx_last, mrx_data};
    end
  end

  // Rx write pointer and flow control toward the MAC.
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wr_r     <= {RXW{1'b0}};
      rx_used_r   <= {(RXW+1){1'b0}};
      mrx_ready_r <= 1'b0;
      rx_empty_r  <= 1'b1;
    end else begin
      if (rx_push) begin
        rx_wr_r <= rx_wr_inc[RXW-1:0];
      end
      // Space is released only on a good handshake.
      rx_used_r   <= rx_used_r + {{RXW{1'b0}}, rx_push}
                   - (hs_ok ? rx_sent_r : {(RXW+1){1'b0}});
      mrx_ready_r <= (rx_used_r < RX_BYTES - 2);
      rx_empty_r  <= (rx_used_r == 0);
    end
  end

  // Bulk-in block builder with retransmit on failed handshake.
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_hd_r     <= {RXW{1'b0}};
      rx_rw_r     <= {RXW{1'b0}};
      rx_sent_r   <= {(RXW+1){1'b0}};
      rx_wait_r   <= 1'b0;
      bin_data_r  <= 8'h00;
      bin_valid_r <= 1'b0;
      bin_last_r  <= 1'b0;
    end else if (rx_wait_r) begin
      // Hold until the host answers the block.
      if (bin_hs_valid & (bin_hs == `UEF_HS_ACK)) begin
        rx_hd_r   <= rx_rw_r;
        rx_sent_r <= {(RXW+1){1'b0}};
        rx_wait_r <= 1'b0;
      end else if (bin_hs_valid) begin
        rx_rw_r   <= rx_hd_r;
        rx_sent_r <= {(RXW+1){1'b0}};
        rx_wait_r <= 1'b0;
      end
    end else if (rx_take & blk_end) begin
      bin_valid_r <= 1'b0;
      bin_last_r  <= 1'b0;
      rx_wait_r   <= 1'b1;
    end else if (~bin_valid_r | rx_take) begin
      if (rx_used_r > rx_sent_r) begin
        // Next stored byte; a block ends at 512 bytes, at a frame end in single mode,
        // or at a frame end with nothing stored behind it. Running dry in mid-frame
        // only pauses the block, so a frame that is still arriving is cut only at the 512-byte limit.
        bin_data_r  <= rxm_r[rx_rw_r][7:0];
        bin_valid_r <= 1'b1;
        bin_last_r  <= (rx_sent_r == `UEF_BLOCK_BYTES - 1) |
                       (rxm_r[rx_rw_r][8] & (encap_mode == `UEF_MODE_SINGLE)) |
                       (rxm_r[rx_rw_r][8] & rx_one_left);
        rx_rw_r     <= rx_rw_inc[RXW-1:0];
        rx_sent_r   <= rx_sent_inc;
      end else begin
        bin_valid_r <= 1'b0;
      end
    end
  end
endmodule // uef_fifo

// >>> bench/uef_fifo_props.sv
module uef_fifo_chk (
  // Clock and reset.
  input wire       clk_sys, sys_rst,
  // Watched ports.
  input wire       bout_valid, bout_last, bout_err, bout_nak_r,
  input wire [7:0] mtx_data_r, bin_data_r,
  input wire       mtx_valid_r, mtx_ready, mrx_valid, mrx_ready_r,
  input wire       bin_valid_r, bin_last_r, bin_ready, bin_hs_valid,
  input wire [1:0] bin_hs,
  input wire       rx_empty_r, tx_empty_r
);
  timeunit 1ns;
  timeprecision 1ns;
  reg wait_r; // A block went out and its handshake is pending.
  // Track the handshake wait, since the ports alone do not show it.
  always @(posedge clk_sys or posedge sys_rst)
    if (sys_rst) wait_r <= 1'b0;
    else if (bin_hs_valid) wait_r <= 1'b0;
    else if (bin_valid_r && bin_ready && bin_last_r) wait_r <= 1'b1;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  property p_mtx_hold; mtx_valid_r && !mtx_ready |=> mtx_valid_r && $stable(mtx_data_r);
  endproperty
  a_mtx_hold: assert property (p_mtx_hold) else $error("mac byte moved");
  property p_bin_hold; bin_valid_r && !bin_ready |=> bin_valid_r && $stable(bin_data_r);
  endproperty
  a_bin_hold: assert property (p_bin_hold) else $error("bulk byte moved");
  property p_bin_wait; wait_r |-> !bin_valid_r; endproperty
  a_bin_wait: assert property (p_bin_wait) else $error("sent while waiting");
  property p_resend; wait_r && bin_hs_valid && bin_hs == 2'h2 |-> ##[1:8] bin_valid_r;
  endproperty
  a_resend: assert property (p_resend) else $error("no resend");
  property p_rx_fill; mrx_valid && mrx_ready_r |-> ##[1:4] !rx_empty_r; endproperty
  a_rx_fill: assert property (p_rx_fill) else $error("rx byte lost");
  property p_tx_fill; bout_valid && !bout_nak_r && bout_last && !bout_err
    |-> ##[1:4] !tx_empty_r; endproperty
  a_tx_fill: assert property (p_tx_fill) else $error("packet lost");
  property p_flush; tx_empty_r && bout_valid && !bout_nak_r && bout_last && bout_err
    |=> tx_empty_r [*4]; endproperty
  a_flush: assert property (p_flush) else $error("bad packet kept");
  property p_nak; tx_empty_r |-> !bout_nak_r; endproperty
  a_nak: assert property (p_nak) else $error("nak when empty");
  c_retry: cover property (wait_r && bin_hs_valid && bin_hs == 2'h2);
  c_full: cover property (bout_nak_r);
  c_flush: cover property (bout_valid && bout_last && bout_err);
endmodule // uef_fifo_chk
bind uef_fifo uef_fifo_chk u_chk (.clk_sys, .sys_rst, .bout_valid, .bout_last, .bout_err,
  .bout_nak_r, .mtx_data_r, .bin_data_r, .mtx_valid_r, .mtx_ready, .mrx_valid, .mrx_ready_r,
  .bin_valid_r, .bin_last_r, .bin_ready, .bin_hs_valid, .bin_hs, .rx_empty_r, .tx_empty_r);

// >>> bench/uef_sink.sv
module uef_sink (
  // Clock and reset.
  input  wire       clk_sys,
  input  wire       sys_rst,
  // Stream, and pace: 0 prompt, 1 slow, 2 halted.
  input  wire [7:0] data,
  input  wire       valid,
  input  wire       last,
  input  wire [1:0] stall,
  output wire       ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];      // Bytes taken, in order.
  int         nlast = 0; // Frame or block ends taken.
  logic [1:0] ph_r;      // Pace phase.
  // A slow sink takes one beat in four, as a busy MAC or host would.
  assign ready = (stall == 2'h0) || (stall == 2'h1 && ph_r == 2'h3);
  // Phase counter.
  always @(posedge clk_sys or posedge sys_rst)
    if (sys_rst) ph_r <= 2'h0;
    else ph_r <= ph_r + 2'h1;
  // A beat counts only at an edge where both sides agree.
  always @(posedge clk_sys)
    if (!sys_rst && valid && ready) begin
      q.push_back(data);
      nlast += last;
    end
endmodule // uef_sink

// >>> bench/tb.sv
`include "uefifo_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // Stimulus, driven at the falling edge.
  logic        clk_sys = 1'b0, sys_rst = 1'b1, encap_mode = 1'b0;
  logic [7:0]  bout_data = 8'h00, mrx_data = 8'h00;
  logic        bout_valid = 1'b0, bout_last = 1'b0, bout_err = 1'b0;
  logic        mrx_valid = 1'b0, mrx_last = 1'b0, bin_hs_valid = 1'b0;
  logic [1:0]  bin_hs = 2'h0, ms_stall = 2'h0, bs_stall = 2'h0;
  wire  [7:0]  mtx_data_r, bin_data_r;
  wire         mtx_valid_r, mtx_last_r, mtx_ready, mrx_ready_r, bout_nak_r;
  wire         bin_valid_r, bin_last_r, bin_ready, rx_empty_r, tx_empty_r;
  int          n_errors = 0, n_tests = 0, nf = 0;
  logic [7:0]  exp_q[$]; // Bytes the MAC should see.
  // Rows: frames the MAC should see, mode, bad flag, length; a bad row must never reach it.
  logic [12:0] rows [4] = '{13'h1001, 13'h1805, 13'h0407, 13'h1200};
  always #2 clk_sys = ~clk_sys;
  uef_fifo u_dut (.clk_sys, .sys_rst, .encap_mode, .bout_data, .bout_valid, .bout_last,
    .bout_err, .bout_nak_r, .mtx_data_r, .mtx_valid_r, .mtx_last_r, .mtx_ready, .mrx_data,
    .mrx_valid, .mrx_last, .mrx_ready_r, .bin_data_r, .bin_valid_r, .bin_last_r, .bin_ready,
    .bin_hs, .bin_hs_valid, .rx_empty_r, .tx_empty_r);
  uef_sink u_ms (.clk_sys, .sys_rst, .data(mtx_data_r), .valid(mtx_valid_r),
    .last(mtx_last_r), .stall(ms_stall), .ready(mtx_ready));
  uef_sink u_bs (.clk_sys, .sys_rst, .data(bin_data_r), .valid(bin_valid_r),
    .last(bin_last_r), .stall(bs_stall), .ready(bin_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait: k < 0 for a drained MAC side, else for k block ends.
  task automatic hold(input int k, input int n);
    repeat (4) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_sys);
      if (k < 0 ? tx_empty_r === 1'b1 && mtx_valid_r === 1'b0 : u_bs.nlast >= k) return;
    end
    n_errors++;
    conclude();
  endtask
  // One bulk-out packet, bytes back to back.
  task automatic send(input int len, input logic err);
    for (int i = 0; i < len; i++) begin
      bout_data = 8'(i + len);
      bout_valid = 1'b1;
      bout_last = (i == len - 1);
      bout_err = err && bout_last;
      if (!err) exp_q.push_back(bout_data);
      @(negedge clk_sys);
    end
    {bout_valid, bout_last, bout_err} = 3'h0;
  endtask
  // One received MAC frame, bytes back to back; the ready level is not watched.
  task automatic rsend(input int len);
    for (int i = 0; i < len; i++) begin
      {mrx_data, mrx_valid, mrx_last} = {8'(i), 1'b1, i == len - 1};
      @(negedge clk_sys);
    end
    {mrx_valid, mrx_last} = 2'h0;
  endtask
  // One handshake pulse from the core.
  task automatic hs(input logic [1:0] code);
    {bin_hs, bin_hs_valid} = {code, 1'b1};
    @(negedge clk_sys);
    // Unused code bits are held at zero between handshakes.
    {bin_hs, bin_hs_valid} = 3'h0;
  endtask
  initial begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk({rx_empty_r, tx_empty_r, bout_nak_r, mtx_valid_r, bin_valid_r}, 5'h18);
    repeat (2) @(negedge clk_sys);
    foreach (rows[r]) begin
      encap_mode = rows[r][11];
      send(rows[r][9:0], rows[r][10]);
      hold(-1, 2000);
      nf += rows[r][12];
      chk(u_ms.nlast, nf);
      $display("row %0d done", r);
    end
    // Fill the transmit side against a halted MAC, then drain it slowly.
    ms_stall = 2'h2;
    repeat (16) begin
      chk(bout_nak_r, 1'b0);
      send(512, 1'b0);
      repeat (3) @(negedge clk_sys);
    end
    chk(bout_nak_r, 1'b1);
    ms_stall = 2'h1;
    hold(-1, 40000);
    chk(bout_nak_r, 1'b0);
    chk(u_ms.nlast, nf + 16);
    foreach (exp_q[i]) chk(u_ms.q[i], exp_q[i]);
    chk(u_ms.q.size(), exp_q.size());
    $display("tx fill done");
    // One frame per packet, a failed handshake, then success.
    {encap_mode, bs_stall} = {`UEF_MODE_SINGLE, 2'h1};
    chk(mrx_ready_r, 1'b1);
    rsend(4);
    hold(1, 2000);
    chk(u_bs.q.size(), 4);
    hs(`UEF_HS_FAIL);
    hold(2, 2000);
    for (int i = 0; i < 8; i++) chk(u_bs.q[i], i % 4);
    chk(rx_empty_r, 1'b0);
    hs(`UEF_HS_ACK);
    repeat (4) @(negedge clk_sys);
    chk(rx_empty_r, 1'b1);
    // A long frame splits into a full block and a short one.
    encap_mode = `UEF_MODE_MULTI;
    rsend(600);
    hold(3, 4000);
    chk(u_bs.q.size(), 520);
    hs(`UEF_HS_ACK);
    hold(4, 2000);
    chk(u_bs.q.size(), 608);
    chk(u_bs.q[607], 8'h57);
    hs(`UEF_HS_ACK);
    repeat (4) @(negedge clk_sys);
    chk(rx_empty_r, 1'b1);
    $display("rx blocks done");
    // A reset in mid-block returns every output to its idle value.
    rsend(3);
    repeat (2) @(negedge clk_sys);
    chk(bin_valid_r, 1'b1);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk({rx_empty_r, tx_empty_r, bout_nak_r, mtx_valid_r, bin_valid_r}, 5'h18);
    repeat (2) @(negedge clk_sys);
    chk(mrx_ready_r, 1'b1);
    $display("reset done");
    conclude();
  end
endmodule // tb
